/* rtl/spc_pkg.sv */
// Functional notes
// - Detect mode-fault, overrun, parity; one error interrupt.
// - Master receive with auto-stop halts clock, no overrun.
// - Software bit enables serial clock auto-stop.
// - Four slave-select lines, numbered 0 to 3.
// - Single master drives all four select lines.
// - Multi-master: line 0 input, others output/unused.
// - Slave: line 0 input, lines 1-3 unused.
// - Select-to-clock delay 1 to 8 periods.
// - Clock-stop-to-negate delay 1 to 8 periods.
// - Next-access idle wait 1 to 8 periods.
// - Up to eight commands run in a loop.
// - Each command carries its own transfer settings.
// - Master transfer starts on transmit buffer write.
// - Idle MOSI level selectable by software.
// - Interrupts on receive full, transmit empty.
// - Idle interrupt while no transfer runs.
// - Event pulses: rx full, tx empty, error, idle, end.
// - Status flags for tx empty, rx full.
// - Each output pin push-pull or open-drain.
// - Software init returns transfer state to start.
// - Module stop freezes state; divider count and event pulses clear.
// - Master clock divides system clock by 2..32768.
// - Slave clock at most clk/8, phases >= 4 cycles.
// - Frames 8-16, 20, 24, 32 bits; MSB/LSB first.
// - 128-bit double buffers, up to four frames.
package spc_pkg;
    localparam int          CMD_NUM    = 8;
    localparam int          FRM_NUM    = 4;
    localparam int          WORD_W     = 32;
    localparam int          BR_W       = 11;
    localparam int          SLV_HALF   = 4;
    localparam logic [1:0]  MODE_SINGLE = 2'h0;
    localparam logic [1:0]  MODE_MULTI  = 2'h1;
    localparam logic [1:0]  MODE_SLAVE  = 2'h2;
    // Command word layout
    localparam int          CF_CPHA    = 0;
    localparam int          CF_CPOL    = 1;
    localparam int          CF_BRDV    = 2;
    localparam int          CF_SSLA    = 4;
    localparam int          CF_LSBF    = 6;
    localparam int          CF_LEN     = 7;
    localparam int          CF_BURST   = 11;
    localparam int          CF_SCKD    = 12;
    localparam int          CF_SLND    = 15;
    localparam int          CF_SPND    = 18;
    localparam int          CMD_W      = 21;
    localparam logic [20:0] CMD_RST    = 21'h000000;
    localparam logic [3:0]  SSL_RST    = 4'hF;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_WAIT, ST_LAG, ST_NEXT, ST_SLAVE} spc_state_t;

    function automatic logic [5:0] spc_len_bits(input logic [3:0] c);
        if (c <= 4'h8) begin
            return 6'h08 + {2'h0, c};
        end else if (c == 4'h9) begin
            return 6'h14;
        end else if (c == 4'hA) begin
            return 6'h18;
        end
        return 6'h20;
    endfunction
endpackage

/* rtl/spc_baud_if.sv */
`timescale 1ns/100ps
interface spc_baud_if;
    logic        run;
    logic [10:0] spbr;
    logic [1:0]  brdv;
    logic        tick;
    modport ctl (output run, output spbr, output brdv, input tick);
    modport gen (input run, input spbr, input brdv, output tick);
endinterface

/* rtl/spc_sync.sv */
`timescale 1ns/100ps
module spc_sync import spc_pkg::*; #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            q_o  <= s1_r;
        end
    end
endmodule

/* rtl/spc_baud.sv */
`timescale 1ns/100ps
module spc_baud import spc_pkg::*; (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    spc_baud_if.gen   bif
);
    logic [14:0] cnt_r;
    logic [14:0] half_w;
    logic [14:0] lim_w;

    // Half period is (spbr+1) << brdv cycles
    assign half_w = (15'(bif.spbr) + 15'h0001) << bif.brdv;
    assign lim_w  = half_w - 15'h0001;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !bif.run) begin
            cnt_r    <= 15'h0000;
            bif.tick <= 1'b0;
        end else if (cnt_r == lim_w) begin
            cnt_r    <= 15'h0000;
            bif.tick <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 15'h0001;
            bif.tick <= 1'b0;
        end
    end
endmodule

/* rtl/spc_top.sv */
`timescale 1ns/100ps
module spc_top import spc_pkg::*; (
    input  wire logic          CLK_I,
    input  wire logic          RESET_N_I,
    input  wire logic          MSTOP_I,
    input  wire logic          SW_INIT_I,
    input  wire logic [1:0]    MODE_I,
    input  wire logic [10:0]   SPBR_I,
    input  wire logic [2:0]    SEQ_LAST_I,
    input  wire logic [1:0]    FRAMES_I,
    input  wire logic          CLOCK_AUTOSTOP_EN_I,
    input  wire logic          PAR_EN_I,
    input  wire logic          PAR_ODD_I,
    input  wire logic          LOOPBACK_I,
    input  wire logic          OD_EN_I,
    input  wire logic          MOSI_IDLE_I,
    input  wire logic [3:0]    SSL_POL_I,
    input  wire logic          CMD_WE_I,
    input  wire logic [2:0]    CMD_IDX_I,
    input  wire logic [20:0]   CMD_DATA_I,
    input  wire logic          TX_WE_I,
    input  wire logic [31:0]   TX_DATA_I,
    input  wire logic          RX_RD_I,
    input  wire logic          ERR_CLR_I,
    input  wire logic          SCK_I,
    input  wire logic          MOSI_I,
    input  wire logic          MISO_I,
    input  wire logic [3:0]    SSL_I,
    output logic               SCK_O,
    output logic               SCK_OE_O,
    output logic               MOSI_O,
    output logic               MOSI_OE_O,
    output logic               MISO_O,
    output logic               MISO_OE_O,
    output logic [3:0]         SSL_O,
    output logic [3:0]         SSL_OE_O,
    output logic [127:0]       RX_DATA_O,
    output logic               TX_BUFFER_EMPTY_FLAG_O,
    output logic               RX_BUFFER_FULL_FLAG_O,
    output logic               MODF_O,
    output logic               OVRF_O,
    output logic               PERF_O,
    output logic               IRQ_ERR_O,
    output logic               IRQ_IDLE_O,
    output logic               EV_RXFULL_O,
    output logic               EV_TXEMPTY_O,
    output logic               EV_ERR_O,
    output logic               EV_IDLE_O,
    output logic               EV_TXEND_O
);
    // ****************************************
    // Storage and state
    // ****************************************
    spc_state_t       st_r;
    logic [CMD_W-1:0] cmd_r [CMD_NUM];
    logic [2:0]       cidx_r;
    logic [31:0]      tx_buf_r [FRM_NUM];
    logic [31:0]      sh_buf_r [FRM_NUM];
    logic [31:0]      rx_wk_r [FRM_NUM];
    logic [1:0]       tx_wp_r, frm_r;
    logic [31:0]      tx_sh_r, rx_sh_r;
    logic [5:0]       bit_r;
    logic [3:0]       dcnt_r;
    logic             tx_par_r, rx_par_r, sck_r, ssl_on_r, rxp_r, s_sck_prev_r;
    logic             tx_empty_r, rx_full_r, modf_r, ovr_r, per_r, idle_r;
    logic             s_sck, s_mosi, s_miso, s_ssl0;

    spc_baud_if bif ();

    // ****************************************
    // Decode
    // ****************************************
    wire [CMD_W-1:0] cur      = cmd_r[MODE_I == MODE_SLAVE ? 3'h0 : cidx_r];
    wire             cpha     = cur[CF_CPHA];
    wire             cpol     = cur[CF_CPOL];
    wire             lsbf     = cur[CF_LSBF];
    wire             burst    = cur[CF_BURST];
    wire [1:0]       ssla     = cur[CF_SSLA+:2];
    wire [5:0]       len      = spc_len_bits(cur[CF_LEN+:4]);
    wire             slave    = MODE_I == MODE_SLAVE;
    wire             multi    = MODE_I == MODE_MULTI;
    wire             ssl0_act = s_ssl0 == SSL_POL_I[0];
    wire             tick     = bif.tick;
    wire [2:0]       dsel     = st_r == ST_LEAD ? cur[CF_SCKD+:3] :
                                st_r == ST_LAG  ? cur[CF_SLND+:3] : cur[CF_SPND+:3];
    wire             dly_done = tick && dcnt_r == {dsel, 1'b1};
    wire [5:0]       sh_amt   = 6'h20 - len;

    // Serial edges: master from divider, slave from synced pin
    wire             m_edge   = st_r == ST_XFER && tick;
    wire             s_edge   = st_r == ST_SLAVE && s_sck != s_sck_prev_r;
    wire             new_lvl  = slave ? s_sck : ~sck_r;
    wire             edge_w   = m_edge || s_edge;
    wire             lead     = edge_w && new_lvl != cpol;
    wire             trail    = edge_w && new_lvl == cpol;
    wire             samp     = cpha ? trail : lead;
    wire             drv      = cpha ? lead : trail;
    wire             last     = bit_r == len - 6'h01;
    wire             dbit     = lsbf ? tx_sh_r[0] : tx_sh_r[31];
    wire             out_bit  = (PAR_EN_I && last) ? (tx_par_r ^ PAR_ODD_I) : dbit;
    wire             rx_in    = LOOPBACK_I ? out_bit : (slave ? s_mosi : s_miso);
    wire [31:0]      nsh      = lsbf ? {rx_in, rx_sh_r[31:1]} : {rx_sh_r[30:0], rx_in};
    wire [31:0]      rx_src   = cpha ? nsh : rx_sh_r;
    wire [31:0]      rx_word  = lsbf ? rx_src >> sh_amt : rx_src;
    wire             fdone    = trail && (cpha ? last : bit_r == len);
    wire             rnd_done = fdone && frm_r == FRAMES_I;
    wire             start_m  = st_r == ST_IDLE && !slave && !tx_empty_r && !modf_r;
    wire             start_s  = st_r == ST_IDLE && slave && ssl0_act;
    wire             take_w   = (start_m || (start_s && !tx_empty_r) ||
                                (st_r == ST_SLAVE && rnd_done && !tx_empty_r)) && !MSTOP_I;
    wire             run      = !MSTOP_I;
    wire             next_end = st_r == ST_NEXT && dly_done;

    // Errors: hardware set wins over software clear
    wire modf_set = run && ((multi && ssl0_act && st_r != ST_IDLE) ||
                    (st_r == ST_SLAVE && !ssl0_act && (bit_r != 6'h00 || frm_r != 2'h0)));
    wire per_set  = run && samp && last && PAR_EN_I && ((rx_par_r ^ rx_in) != PAR_ODD_I);
    wire ovr_set  = run && rxp_r && rx_full_r && !(CLOCK_AUTOSTOP_EN_I && !slave);
    wire rx_store = run && rxp_r && !rx_full_r;
    wire idle_w   = (st_r == ST_IDLE) && tx_empty_r;

    function automatic logic [31:0] align(input logic [31:0] w, input logic lf, input logic [5:0] s);
        return lf ? w : w << s;
    endfunction

    assign bif.run  = run && (st_r == ST_LEAD || st_r == ST_XFER || st_r == ST_LAG || st_r == ST_NEXT);
    assign bif.spbr = SPBR_I;
    assign bif.brdv = cur[CF_BRDV+:2];

    spc_baud u_baud (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .bif     (bif.gen)
    );

    // Two-stage sync; slave phases of four cycles stay visible
    spc_sync #(.W(4)) u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .d_i     ({SCK_I, MOSI_I, MISO_I, SSL_I[0]}),
        .q_o     ({s_sck, s_mosi, s_miso, s_ssl0})
    );

    // ****************************************
    // Command table and transmit buffer
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            for (int i = 0; i < CMD_NUM; i++) begin
                cmd_r[i] <= CMD_RST;
            end
        end else if (CMD_WE_I && run) begin
            cmd_r[CMD_IDX_I] <= CMD_DATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || SW_INIT_I) begin
            tx_wp_r    <= 2'h0;
            tx_empty_r <= 1'b1;
        end else if (run) begin
            if (take_w) begin
                tx_empty_r <= 1'b1;
            end else if (TX_WE_I && tx_empty_r) begin
                tx_buf_r[tx_wp_r] <= TX_DATA_I;
                tx_wp_r           <= tx_wp_r == FRAMES_I ? 2'h0 : tx_wp_r + 2'h1;
                tx_empty_r        <= tx_wp_r != FRAMES_I;
            end
        end
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || SW_INIT_I) begin
            st_r         <= ST_IDLE;
            cidx_r       <= 3'h0;
            frm_r        <= 2'h0;
            bit_r        <= 6'h00;
            dcnt_r       <= 4'h0;
            tx_sh_r      <= 32'h00000000;
            rx_sh_r      <= 32'h00000000;
            tx_par_r     <= 1'b0;
            rx_par_r     <= 1'b0;
            sck_r        <= 1'b0;
            ssl_on_r     <= 1'b0;
            rxp_r        <= 1'b0;
            s_sck_prev_r <= 1'b0;
        end else if (run) begin
            s_sck_prev_r <= s_sck;
            if (rxp_r && (!rx_full_r || ovr_set)) begin
                rxp_r <= 1'b0;
            end
            if (start_m || start_s) begin
                sh_buf_r <= tx_buf_r;
                tx_sh_r  <= align(tx_buf_r[0], lsbf, sh_amt);
                frm_r    <= 2'h0;
                bit_r    <= 6'h00;
                tx_par_r <= 1'b0;
                rx_par_r <= 1'b0;
                rx_sh_r  <= 32'h00000000;
                dcnt_r   <= 4'h0;
                sck_r    <= cpol;
            end
            if (samp) begin
                rx_sh_r  <= nsh;
                bit_r    <= bit_r + 6'h01;
                tx_par_r <= tx_par_r ^ out_bit;
                rx_par_r <= rx_par_r ^ rx_in;
                tx_sh_r  <= lsbf ? tx_sh_r >> 1 : tx_sh_r << 1;
            end
            if (fdone) begin
                rx_wk_r[frm_r] <= rx_word;
                bit_r          <= 6'h00;
                tx_par_r       <= 1'b0;
                rx_par_r       <= 1'b0;
                rx_sh_r        <= 32'h00000000;
                frm_r          <= rnd_done ? 2'h0 : frm_r + 2'h1;
                tx_sh_r        <= align(sh_buf_r[rnd_done ? 2'h0 : frm_r + 2'h1], lsbf, sh_amt);
                rxp_r          <= rnd_done;
            end
            if (take_w && st_r == ST_SLAVE) begin
                sh_buf_r <= tx_buf_r;
                tx_sh_r  <= align(tx_buf_r[0], lsbf, sh_amt);
            end
            case (st_r)
                ST_IDLE: begin
                    if (start_s) begin
                        st_r <= ST_SLAVE;
                    end else if (start_m) begin
                        st_r     <= ST_LEAD;
                        ssl_on_r <= 1'b1;
                    end
                end
                ST_LEAD: begin
                    dcnt_r <= tick ? dcnt_r + 4'h1 : dcnt_r;
                    if (dly_done) begin
                        st_r <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (tick) begin
                        sck_r <= ~sck_r;
                    end
                    if (rnd_done) begin
                        st_r   <= ST_WAIT;
                        dcnt_r <= 4'h0;
                    end
                end
                ST_WAIT: begin
                    if (!rxp_r) begin
                        st_r <= ST_LAG;
                    end
                end
                ST_LAG: begin
                    dcnt_r <= tick ? dcnt_r + 4'h1 : dcnt_r;
                    if (dly_done) begin
                        st_r     <= ST_NEXT;
                        dcnt_r   <= 4'h0;
                        ssl_on_r <= burst && !tx_empty_r;
                    end
                end
                ST_NEXT: begin
                    dcnt_r <= tick ? dcnt_r + 4'h1 : dcnt_r;
                    if (dly_done) begin
                        st_r   <= ST_IDLE;
                        cidx_r <= cidx_r == SEQ_LAST_I ? 3'h0 : cidx_r + 3'h1;
                    end
                end
                ST_SLAVE: begin
                    if (!ssl0_act) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
            if (multi && ssl0_act && st_r != ST_IDLE && st_r != ST_SLAVE) begin
                st_r     <= ST_IDLE;
                ssl_on_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Receive buffer, flags and events
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || SW_INIT_I) begin
            rx_full_r    <= 1'b0;
            modf_r       <= 1'b0;
            ovr_r        <= 1'b0;
            per_r        <= 1'b0;
            idle_r       <= 1'b0;
            RX_DATA_O    <= '0;
            IRQ_ERR_O    <= 1'b0;
            EV_RXFULL_O  <= 1'b0;
            EV_TXEMPTY_O <= 1'b0;
            EV_ERR_O     <= 1'b0;
            EV_IDLE_O    <= 1'b0;
            EV_TXEND_O   <= 1'b0;
        end else if (run) begin
            if (rx_store) begin
                RX_DATA_O <= {rx_wk_r[3], rx_wk_r[2], rx_wk_r[1], rx_wk_r[0]};
            end
            rx_full_r    <= rx_store || (rx_full_r && !RX_RD_I);
            modf_r       <= modf_set || (modf_r && !ERR_CLR_I);
            ovr_r        <= ovr_set || (ovr_r && !ERR_CLR_I);
            per_r        <= per_set || (per_r && !ERR_CLR_I);
            IRQ_ERR_O    <= modf_set || ovr_set || per_set ||
                            ((modf_r || ovr_r || per_r) && !ERR_CLR_I);
            idle_r       <= idle_w;
            EV_RXFULL_O  <= rx_store;
            EV_TXEMPTY_O <= take_w;
            EV_ERR_O     <= modf_set || ovr_set || per_set;
            EV_IDLE_O    <= idle_w && !idle_r;
            EV_TXEND_O   <= next_end && tx_empty_r;
        end else begin
            EV_RXFULL_O  <= 1'b0;
            EV_TXEMPTY_O <= 1'b0;
            EV_ERR_O     <= 1'b0;
            EV_IDLE_O    <= 1'b0;
            EV_TXEND_O   <= 1'b0;
        end
    end

    assign TX_BUFFER_EMPTY_FLAG_O = tx_empty_r;
    assign RX_BUFFER_FULL_FLAG_O  = rx_full_r;
    assign MODF_O                 = modf_r;
    assign OVRF_O                 = ovr_r;
    assign PERF_O                 = per_r;
    assign IRQ_IDLE_O             = idle_r;

    // ****************************************
    // Pin drivers
    // ****************************************
    logic [3:0] ssl_val, ssl_oe;
    logic       out_r;
    wire        m_act   = !slave;
    wire        out_nxt = (m_act && !ssl_on_r) ? MOSI_IDLE_I :
                          (drv || (st_r != ST_XFER && st_r != ST_SLAVE)) ? out_bit : out_r;

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_ssl
            wire act = ssl_on_r && ssla == 2'(k);
            assign ssl_val[k] = act ? SSL_POL_I[k] : ~SSL_POL_I[k];
            // Line 0 is an input in multi and slave; all lines idle in slave
            assign ssl_oe[k]  = !slave && (MODE_I == MODE_SINGLE || k != 0) &&
                                (!OD_EN_I || !ssl_val[k]);
        end
    endgenerate

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            out_r     <= 1'b0;
            SCK_O     <= 1'b0;
            SCK_OE_O  <= 1'b0;
            MOSI_OE_O <= 1'b0;
            MISO_OE_O <= 1'b0;
            SSL_O     <= SSL_RST;
            SSL_OE_O  <= 4'h0;
        end else if (run) begin
            out_r     <= out_nxt;
            SCK_O     <= sck_r;
            SCK_OE_O  <= m_act && (!OD_EN_I || !sck_r);
            MOSI_OE_O <= m_act && (!OD_EN_I || !out_nxt);
            MISO_OE_O <= st_r == ST_SLAVE && (!OD_EN_I || !out_nxt);
            SSL_O     <= ssl_val;
            SSL_OE_O  <= ssl_oe;
        end
    end

    assign MOSI_O = out_r;
    assign MISO_O = out_r;
endmodule

/* test/spc_sva.sv */
`timescale 1ns/100ps
// ********
// Checks
// ********
module spc_sva import spc_pkg::*; (
    input wire logic       CLK_I,
    input wire logic       RESET_N_I,
    input wire logic       SW_INIT_I,
    input wire logic [1:0] MODE_I,
    input wire logic       TX_WE_I,
    input wire logic       CLOCK_AUTOSTOP_EN_I,
    input wire logic       OD_EN_I,
    input wire logic       MOSI_O,
    input wire logic       MOSI_OE_O,
    input wire logic [3:0] SSL_OE_O,
    input wire logic       TX_BUFFER_EMPTY_FLAG_O,
    input wire logic       MODF_O,
    input wire logic       OVRF_O,
    input wire logic       PERF_O,
    input wire logic       IRQ_ERR_O,
    input wire logic       EV_TXEMPTY_O,
    input wire logic       EV_TXEND_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_err; (MODF_O || OVRF_O || PERF_O) |-> ##[0:1] IRQ_ERR_O; endproperty
    a_err: assert property (p_err) else $error("error irq missing");
    property p_stop; CLOCK_AUTOSTOP_EN_I && $past(CLOCK_AUTOSTOP_EN_I) && MODE_I != MODE_SLAVE |-> !$rose(OVRF_O);
    endproperty
    a_stop: assert property (p_stop) else $error("overrun with autostop");
    property p_slv; MODE_I == MODE_SLAVE && $past(MODE_I) == MODE_SLAVE |-> SSL_OE_O == 4'h0; endproperty
    a_slv: assert property (p_slv) else $error("slave drives select");
    property p_mm; MODE_I == MODE_MULTI && $past(MODE_I) == MODE_MULTI |-> !SSL_OE_O[0]; endproperty
    a_mm: assert property (p_mm) else $error("multi drives line 0");
    property p_txf; $fell(TX_BUFFER_EMPTY_FLAG_O) |-> $past(TX_WE_I); endproperty
    a_txf: assert property (p_txf) else $error("tx flag fell unwritten");
    property p_txr; $rose(TX_BUFFER_EMPTY_FLAG_O) && !$past(SW_INIT_I) |-> EV_TXEMPTY_O; endproperty
    a_txr: assert property (p_txr) else $error("tx empty event missing");
    property p_end; EV_TXEND_O |=> !EV_TXEND_O; endproperty
    a_end: assert property (p_end) else $error("end event too long");
    property p_od; OD_EN_I && $past(OD_EN_I) && MOSI_OE_O |-> !MOSI_O; endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    c_end: cover property (EV_TXEND_O);
    c_ovr: cover property ($rose(OVRF_O));
    c_modf: cover property ($rose(MODF_O));
endmodule

/* test/spc_slave_model.sv */
`timescale 1ns/100ps
// ********
// Far-side slave, answers inverted MOSI
// ********
module spc_slave_model (
    input  wire logic clk_i,
    input  wire logic sel_n_i,
    input  wire logic slow_i,
    input  wire logic mosi_i,
    output logic      miso_o
);
    logic mosi_r;
    logic tgl_r = 1'b0;
    always @(posedge clk_i) begin
        mosi_r <= mosi_i;
        tgl_r  <= ~tgl_r;
    end
    assign miso_o = sel_n_i ? tgl_r : ~(slow_i ? mosi_r : mosi_i);
endmodule

/* test/spc_top_tb.sv */
`timescale 1ns/100ps
// ********
// Bench
// ********
module spc_top_tb;
    logic CLK_I, RESET_N_I, MSTOP_I, SW_INIT_I, CLOCK_AUTOSTOP_EN_I, PAR_EN_I, PAR_ODD_I, LOOPBACK_I, OD_EN_I;
    logic MOSI_IDLE_I, CMD_WE_I, TX_WE_I, RX_RD_I, ERR_CLR_I, SCK_I, MOSI_I, MISO_I, SCK_O, SCK_OE_O, MOSI_O;
    logic MOSI_OE_O, MISO_O, MISO_OE_O, TX_BUFFER_EMPTY_FLAG_O, RX_BUFFER_FULL_FLAG_O, MODF_O, OVRF_O, PERF_O;
    logic IRQ_ERR_O, IRQ_IDLE_O, EV_RXFULL_O, EV_TXEMPTY_O, EV_ERR_O, EV_IDLE_O, EV_TXEND_O, slow;
    logic [1:0]   MODE_I, FRAMES_I;
    logic [2:0]   SEQ_LAST_I, CMD_IDX_I;
    logic [3:0]   SSL_POL_I, SSL_I, SSL_O, SSL_OE_O;
    logic [3:0]   lens [6] = '{4'h0, 4'h5, 4'h8, 4'h9, 4'hA, 4'hF};
    logic [10:0]  SPBR_I;
    logic [20:0]  CMD_DATA_I;
    logic [31:0]  TX_DATA_I, d;
    logic [127:0] RX_DATA_O;
    int           n_errors = 0, comparisons = 0, n;
    int           n_rxev = 0, n_endev = 0, n_errev = 0;
    spc_top spc_top_i (.*);
    spc_slave_model spc_slave_model_i (.clk_i(CLK_I), .sel_n_i(SSL_O[0] ^ SSL_POL_I[0]), .slow_i(slow),
        .mosi_i(MOSI_OE_O ? MOSI_O : 1'b1), .miso_o(MISO_I));
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    // Event pulse counters
    always @(negedge CLK_I) begin
        n_rxev  <= n_rxev + int'(EV_RXFULL_O);
        n_endev <= n_endev + int'(EV_TXEND_O);
        n_errev <= n_errev + int'(EV_ERR_O);
    end
    task automatic give_verdict;
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge CLK_I);
        s = 1'b0;
    endtask
    task automatic start(input logic [20:0] c);
        for (n = 0; n < 9000 && IRQ_IDLE_O !== 1'b1; n++) @(negedge CLK_I);
        if (n == 9000) n_errors++;
        d = $urandom;
        CMD_DATA_I = c;
        pulse(CMD_WE_I);
        chk("mosi_idle", MOSI_IDLE_I, MOSI_O);
        TX_DATA_I = d;
        pulse(TX_WE_I);
    endtask
    task automatic wait_rx;
        for (n = 0; n < 9000 && RX_BUFFER_FULL_FLAG_O !== 1'b1; n++) @(negedge CLK_I);
        if (n == 9000) n_errors++;
    endtask
    function automatic logic [31:0] mask(input logic [3:0] c);
        int b;
        b = c <= 8 ? 8 + c : c == 9 ? 20 : c == 10 ? 24 : 32;
        return b == 32 ? 32'hFFFFFFFF : (32'h1 << b) - 32'h1;
    endfunction
    initial begin
        {MSTOP_I, SW_INIT_I, CLOCK_AUTOSTOP_EN_I, PAR_EN_I, PAR_ODD_I, LOOPBACK_I, OD_EN_I, MOSI_IDLE_I} = '0;
        {CMD_WE_I, TX_WE_I, RX_RD_I, ERR_CLR_I, SCK_I, MOSI_I, slow, RESET_N_I} = '0;
        {MODE_I, FRAMES_I, SEQ_LAST_I, CMD_IDX_I, SSL_POL_I, CMD_DATA_I, TX_DATA_I} = '0;
        SSL_I = 4'hF;
        SPBR_I = 11'h007;
        void'($urandom(32'hC6C0));
        repeat (3) @(negedge CLK_I);
        RESET_N_I = 1'b1;
        chk("txe", 1, TX_BUFFER_EMPTY_FLAG_O);
        chk("ssl", 32'hF, SSL_O);
        foreach (lens[i]) begin
            slow = i[0];
            MOSI_IDLE_I = 1'($urandom);
            start((21'($urandom) & 21'h1FF847) | {10'h0, lens[i], 7'h0});
            wait_rx;
            chk("ssl_oe", 32'hF, SSL_OE_O);
            chk("sck_oe", 1, SCK_OE_O);
            chk("rx", ~d & mask(lens[i]), RX_DATA_O[31:0] & mask(lens[i]));
            pulse(RX_RD_I);
        end
        // Nine-bit frame, inverting far side flips the parity sense
        PAR_EN_I = 1'b1;
        start(21'h80);
        wait_rx;
        chk("perf", 1, PERF_O);
        pulse(RX_RD_I);
        pulse(ERR_CLR_I);
        PAR_EN_I = 1'b0;
        {LOOPBACK_I, OD_EN_I} = 2'h3;
        start(21'h0);
        wait_rx;
        chk("loop", d & 32'hFF, RX_DATA_O[31:0] & 32'hFF);
        pulse(RX_RD_I);
        {LOOPBACK_I, OD_EN_I} = 2'h0;
        start(21'h0);
        wait_rx;
        start(21'h0);
        for (n = 0; n < 9000 && OVRF_O !== 1'b1; n++) @(negedge CLK_I);
        @(negedge CLK_I);
        chk("ovr_irq", 1, IRQ_ERR_O);
        pulse(ERR_CLR_I);
        CLOCK_AUTOSTOP_EN_I = 1'b1;
        start(21'h0);
        repeat (2000) @(negedge CLK_I);
        chk("stop_ovr", 0, OVRF_O);
        chk("stop_ssl", 0, SSL_O[0]);
        pulse(RX_RD_I);
        wait_rx;
        chk("stop_rx", ~d & 32'hFF, RX_DATA_O[31:0] & 32'hFF);
        pulse(RX_RD_I);
        CLOCK_AUTOSTOP_EN_I = 1'b0;
        MODE_I = 2'h1;
        start(21'h10);
        repeat (20) @(negedge CLK_I);
        SSL_I = 4'hE;
        for (n = 0; n < 100 && MODF_O !== 1'b1; n++) @(negedge CLK_I);
        chk("modf", 1, MODF_O);
        SSL_I = 4'hF;
        MODE_I = 2'h2;
        repeat (5) @(negedge CLK_I);
        MODE_I = 2'h0;
        pulse(SW_INIT_I);
        chk("init", 0, MODF_O);
        SSL_POL_I = 4'hF;
        repeat (3) @(negedge CLK_I);
        chk("pol", 0, SSL_O);
        MSTOP_I = 1'b1;
        pulse(TX_WE_I);
        MSTOP_I = 1'b0;
        chk("mstop", 1, TX_BUFFER_EMPTY_FLAG_O);
        chk("ev_rx", 10, n_rxev);
        chk("ev_end", 11, n_endev);
        chk("ev_err", 3, n_errev);
        give_verdict;
    end
    initial begin
        repeat (90000) @(posedge CLK_I);
        n_errors++;
        give_verdict;
    end
endmodule
bind spc_top spc_sva spc_sva_i (.*);
